// ### ebtc_pkg.sv
package ebtc_pkg;
	// Register word addresses (byte offsets on APB)
	localparam logic [7:0] CTRL_A_OFS    = 8'h00;
	localparam logic [7:0] CTRL_B_OFS    = 8'h04;
	localparam logic [7:0] COUNT_OFS     = 8'h08;
	localparam logic [7:0] CMP_A_OFS     = 8'h0C;
	localparam logic [7:0] CMP_B_OFS     = 8'h10;
	localparam logic [7:0] IMASK_OFS     = 8'h14;
	localparam logic [7:0] IFLAG_OFS     = 8'h18;
	localparam logic [7:0] ASYNC_OFS     = 8'h1C;
	localparam logic [7:0] POWER_OFS     = 8'h20;
	// Field positions
	localparam int WGM0_POS  = 0;
	localparam int WGM1_POS  = 1;
	localparam int COMB_POS  = 4;
	localparam int COMA_POS  = 6;
	localparam int CS_POS    = 0;
	localparam int WGM2_POS  = 3;
	localparam int FOCB_POS  = 6;
	localparam int FOCA_POS  = 7;
	localparam int OVF_POS   = 0;
	localparam int MA_POS    = 1;
	localparam int MB_POS    = 2;
	localparam int AS_POS    = 3;
	localparam int PRR_POS   = 0;
	// Counter extremes
	localparam logic [7:0] BOTTOM_VAL = 8'h00;
	localparam logic [7:0] MAX_VAL    = 8'hFF;
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic       POWER_RST  = 1'b0;
	// Prescaler divisors selected by clock-select 2..7
	localparam int PRESC_W = 10;
	localparam logic [9:0] DIV8_MASK    = 10'h007;
	localparam logic [9:0] DIV32_MASK   = 10'h01F;
	localparam logic [9:0] DIV64_MASK   = 10'h03F;
	localparam logic [9:0] DIV128_MASK  = 10'h07F;
	localparam logic [9:0] DIV256_MASK  = 10'h0FF;
	localparam logic [9:0] DIV1024_MASK = 10'h3FF;

	// Waveform modes
	typedef enum logic [2:0] {
		EBTC_NORMAL   = 3'b000,
		EBTC_PC_FF    = 3'b001,
		EBTC_CTC      = 3'b010,
		EBTC_FAST_FF  = 3'b011,
		EBTC_RSV4     = 3'b100,
		EBTC_PC_OCA   = 3'b101,
		EBTC_RSV6     = 3'b110,
		EBTC_FAST_OCA = 3'b111
	} ebtc_wgm_t;
endpackage

// ### ebtc_tick_if.sv
`timescale 1ns/100ps
// Timer clock enable and its setup between top and clock-select unit
interface ebtc_tick_if;
	logic [2:0] clock_select_field;
	logic       async_clock_select;
	logic       enable;
	logic       tick;
	modport sel (input clock_select_field, input async_clock_select, input enable, output tick);
	modport core (output clock_select_field, output async_clock_select, output enable, input tick);
endinterface

// ### ebtc_clksel.sv
`timescale 1ns/100ps
// Clock select: builds the one-cycle timer clock enable
module ebtc_clksel (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic crystal_pin_in,
	ebtc_tick_if.sel  tk
);
	logic [ebtc_pkg::PRESC_W-1:0] presc_q;
	logic [2:0]                   xtal_sync_q;
	logic                         xtal_lvl_q;
	logic                         xtal_rise;
	logic [ebtc_pkg::PRESC_W-1:0] mask;
	logic                         src_tick;

	// Prescaler runs only while enabled, so a restart begins aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= '0;
		end else if (!tk.enable) begin
			presc_q <= '0;
		end else if (src_tick) begin
			presc_q <= presc_q + 1'b1;
		end
	end

	// Crystal input: three stages, a rising change counts when last two agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_sync_q <= '0;
			xtal_lvl_q  <= 1'b0;
		end else begin
			xtal_sync_q <= {xtal_sync_q[1:0], crystal_pin_in};
			if (xtal_sync_q[1] == xtal_sync_q[2]) begin
				xtal_lvl_q <= xtal_sync_q[2];
			end
		end
	end
	assign xtal_rise = (xtal_sync_q[1] == xtal_sync_q[2]) && xtal_sync_q[2] && !xtal_lvl_q;

	assign src_tick = tk.async_clock_select ? xtal_rise : 1'b1;

	// Divisor mask per clock-select value
	always_comb begin
		mask = '0;
		case (tk.clock_select_field)
			3'd2:    mask = ebtc_pkg::DIV8_MASK;
			3'd3:    mask = ebtc_pkg::DIV32_MASK;
			3'd4:    mask = ebtc_pkg::DIV64_MASK;
			3'd5:    mask = ebtc_pkg::DIV128_MASK;
			3'd6:    mask = ebtc_pkg::DIV256_MASK;
			3'd7:    mask = ebtc_pkg::DIV1024_MASK;
			default: mask = '0;
		endcase
	end

	assign tk.tick = tk.enable && (tk.clock_select_field != 3'd0) && src_tick
		&& ((presc_q & mask) == mask);
endmodule

// ### ebtc_timer.sv
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module ebtc_timer #(
	parameter int CNT_W = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             crystal_pin_in,
	input  wire logic             overflow_ack,
	input  wire logic             match_a_ack,
	input  wire logic             match_b_ack,
	output logic                  overflow_irq,
	output logic                  match_a_irq,
	output logic                  match_b_irq,
	output logic                  compare_out_a,
	output logic                  compare_out_b,
	output logic                  compare_out_en_a,
	output logic                  compare_out_en_b
);
	logic [7:0]       control_reg_a_q;
	logic [7:0]       control_reg_b_q;
	logic [CNT_W-1:0] count_value_q;
	logic [CNT_W-1:0] cmp_act_q [2];
	logic [CNT_W-1:0] cmp_buf_q [2];
	logic [2:0]       interrupt_mask_reg_q;
	logic [2:0]       interrupt_flag_reg_q;
	logic             async_clock_select_q;
	logic             timer_power_reduce_bit_q;
	logic             down_q;
	logic             block_q;
	logic [1:0]       match_pend_q;
	logic [1:0]       compare_out_q;
	logic [1:0]       oc_d;
	logic             wr;
	logic             rd_ok;
	logic             cnt_wr;
	logic             tick;
	logic [2:0]       waveform_mode_field;
	logic [CNT_W-1:0] top;
	logic             is_pwm;
	logic             is_pc;
	logic             at_top;
	logic             at_bottom;
	logic [1:0]       match;
	logic [1:0]       compare_output_mode [2];
	logic [1:0]       force_compare_strobe;
	logic [2:0]       flag_set;
	logic [2:0]       flag_clr;
	logic [CNT_W-1:0] count_d;
	logic             upd_cmp;
	logic [31:0]      rd_d;

	ebtc_tick_if tk ();

	ebtc_clksel u_clksel (
		.pclk           (pclk),
		.presetn        (presetn),
		.crystal_pin_in (crystal_pin_in),
		.tk             (tk)
	);

	// Setup to the clock-select unit
	assign tk.clock_select_field = control_reg_b_q[ebtc_pkg::CS_POS +: 3];
	assign tk.async_clock_select = async_clock_select_q;
	assign tk.enable = !timer_power_reduce_bit_q;
	assign tick      = tk.tick;

	// APB: zero wait states, no errors
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr      = psel && penable && pwrite;
	assign cnt_wr  = wr && (paddr == ebtc_pkg::COUNT_OFS);

	// mode assembled from both control registers
	assign waveform_mode_field = {control_reg_b_q[ebtc_pkg::WGM2_POS],
		control_reg_a_q[ebtc_pkg::WGM1_POS], control_reg_a_q[ebtc_pkg::WGM0_POS]};
	assign is_pwm = waveform_mode_field[0];
	assign is_pc  = is_pwm && !waveform_mode_field[1];
	assign top = (waveform_mode_field == 3'd0 || waveform_mode_field == 3'd1
		|| waveform_mode_field == 3'd3) ? ebtc_pkg::MAX_VAL[CNT_W-1:0] : cmp_act_q[0];
	assign at_top    = (count_value_q == top);
	assign at_bottom = (count_value_q == ebtc_pkg::BOTTOM_VAL[CNT_W-1:0]);
	// output modes read live from control A
	assign compare_output_mode[0] = control_reg_a_q[ebtc_pkg::COMA_POS +: 2];
	assign compare_output_mode[1] = control_reg_a_q[ebtc_pkg::COMB_POS +: 2];
	// Strobes only act in non-PWM modes
	assign force_compare_strobe[0] = wr && (paddr == ebtc_pkg::CTRL_B_OFS)
		&& pwdata[ebtc_pkg::FOCA_POS] && !is_pwm;
	assign force_compare_strobe[1] = wr && (paddr == ebtc_pkg::CTRL_B_OFS)
		&& pwdata[ebtc_pkg::FOCB_POS] && !is_pwm;

	// Comparators; suppress after count write
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cmp
			assign match[gi] = (count_value_q == cmp_act_q[gi]) && !block_q && !cnt_wr;
		end
	endgenerate

	// block lasts until the next timer clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_q <= 1'b0;
		end else if (cnt_wr) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	// Match latched, flagged at the next timer clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_pend_q <= '0;
		end else if (tick) begin
			match_pend_q <= match;
		end
	end

	// Counter next value
	always_comb begin
		count_d = count_value_q;
		if (tick) begin
			if (is_pc) begin
				if (down_q) begin
					count_d = count_value_q - 1'b1;
				end else begin
					count_d = count_value_q + 1'b1;
				end
				if (at_top && !down_q) begin
					count_d = count_value_q - 1'b1;
				end else if (at_bottom && down_q) begin
					count_d = count_value_q + 1'b1;
				end
			end else if (waveform_mode_field == 3'd0) begin
				count_d = count_value_q + 1'b1;
			end else if (at_top) begin
				count_d = ebtc_pkg::BOTTOM_VAL[CNT_W-1:0];
			end else begin
				count_d = count_value_q + 1'b1;
			end
		end
	end

	// write wins; no tick holds; eight-bit count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value_q <= '0;
		end else if (cnt_wr) begin
			count_value_q <= pwdata[CNT_W-1:0];
		end else begin
			count_value_q <= count_d;
		end
	end

	// Direction for dual slope
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			down_q <= 1'b0;
		end else if (!is_pc) begin
			down_q <= 1'b0;
		end else if (tick && at_top) begin
			down_q <= 1'b1;
		end else if (tick && at_bottom) begin
			down_q <= 1'b0;
		end
	end

	// buffered update at top (phase correct) or at bottom or top (fast)
	assign upd_cmp = tick && (is_pc ? at_top : at_bottom || at_top);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_act_q[0] <= '0;
			cmp_act_q[1] <= '0;
			cmp_buf_q[0] <= '0;
			cmp_buf_q[1] <= '0;
		end else begin
			if (wr && paddr == ebtc_pkg::CMP_A_OFS) begin
				cmp_buf_q[0] <= pwdata[CNT_W-1:0];
			end
			if (wr && paddr == ebtc_pkg::CMP_B_OFS) begin
				cmp_buf_q[1] <= pwdata[CNT_W-1:0];
			end
			if (!is_pwm) begin
				if (wr && paddr == ebtc_pkg::CMP_A_OFS) begin
					cmp_act_q[0] <= pwdata[CNT_W-1:0];
				end
				if (wr && paddr == ebtc_pkg::CMP_B_OFS) begin
					cmp_act_q[1] <= pwdata[CNT_W-1:0];
				end
			end else if (upd_cmp) begin
				cmp_act_q[0] <= cmp_buf_q[0];
				cmp_act_q[1] <= cmp_buf_q[1];
			end
		end
	end

	// Waveform next value per channel
	always_comb begin
		oc_d = compare_out_q;
		for (int i = 0; i < 2; i++) begin
			if (!is_pwm) begin
				// set, clear or toggle on match or force
				if ((tick && match[i]) || force_compare_strobe[i]) begin
					case (compare_output_mode[i])
						2'd1:    oc_d[i] = !compare_out_q[i];
						2'd2:    oc_d[i] = 1'b0;
						2'd3:    oc_d[i] = 1'b1;
						default: oc_d[i] = compare_out_q[i];
					endcase
				end
			end else if (compare_output_mode[i][1]) begin
				// Inverting when low mode bit set
				if (tick && match[i]) begin
					oc_d[i] = compare_output_mode[i][0] ? !(is_pc && down_q) : (is_pc && down_q);
				end else if (tick && !is_pc && at_top) begin
					oc_d[i] = !compare_output_mode[i][0];
				end
			end
		end
	end

	// output register never reset by mode change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_out_q <= '0;
		end else begin
			compare_out_q <= oc_d;
		end
	end
	assign compare_out_a    = compare_out_q[0];
	assign compare_out_b    = compare_out_q[1];
	// Low while driving: any non-zero output mode takes over the pin
	assign compare_out_en_a = !(compare_output_mode[0] != 2'd0);
	assign compare_out_en_b = !(compare_output_mode[1] != 2'd0);

	// overflow: at top in fast, bottom in phase correct, wrap otherwise
	assign flag_set[ebtc_pkg::OVF_POS] = tick && (is_pc ? (at_bottom && down_q)
		: (is_pwm ? at_top : (count_value_q == ebtc_pkg::MAX_VAL[CNT_W-1:0])))
		&& !cnt_wr;
	// flag one timer clock after the match
	assign flag_set[ebtc_pkg::MA_POS] = tick && match_pend_q[0];
	assign flag_set[ebtc_pkg::MB_POS] = tick && match_pend_q[1];
	assign flag_clr = ({3{wr && paddr == ebtc_pkg::IFLAG_OFS}} & pwdata[2:0])
		| {match_b_ack, match_a_ack, overflow_ack};

	// Set beats clear so no event is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_flag_reg_q <= '0;
		end else begin
			interrupt_flag_reg_q <= (interrupt_flag_reg_q & ~flag_clr) | flag_set;
		end
	end

	assign overflow_irq = interrupt_flag_reg_q[ebtc_pkg::OVF_POS]
		&& interrupt_mask_reg_q[ebtc_pkg::OVF_POS];
	assign match_a_irq  = interrupt_flag_reg_q[ebtc_pkg::MA_POS]
		&& interrupt_mask_reg_q[ebtc_pkg::MA_POS];
	assign match_b_irq  = interrupt_flag_reg_q[ebtc_pkg::MB_POS]
		&& interrupt_mask_reg_q[ebtc_pkg::MB_POS];

	// Control and configuration writes; strobe bits are not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg_a_q          <= ebtc_pkg::RESET_BYTE;
			control_reg_b_q          <= ebtc_pkg::RESET_BYTE;
			interrupt_mask_reg_q     <= '0;
			async_clock_select_q     <= 1'b0;
			timer_power_reduce_bit_q <= ebtc_pkg::POWER_RST;
		end else if (wr) begin
			if (paddr == ebtc_pkg::CTRL_A_OFS) begin
				control_reg_a_q <= pwdata[7:0] & 8'hF3;
			end else if (paddr == ebtc_pkg::CTRL_B_OFS) begin
				control_reg_b_q <= pwdata[7:0] & 8'h0F;
			end else if (paddr == ebtc_pkg::IMASK_OFS) begin
				interrupt_mask_reg_q <= pwdata[2:0];
			end else if (paddr == ebtc_pkg::ASYNC_OFS) begin
				async_clock_select_q <= pwdata[ebtc_pkg::AS_POS];
			end else if (paddr == ebtc_pkg::POWER_OFS) begin
				timer_power_reduce_bit_q <= pwdata[ebtc_pkg::PRR_POS];
			end
		end
	end

	// Read mux; compare reads follow the written path
	assign rd_ok = psel && !pwrite;
	always_comb begin
		rd_d = '0;
		if (paddr == ebtc_pkg::CTRL_A_OFS) begin
			rd_d[7:0] = control_reg_a_q;
		end else if (paddr == ebtc_pkg::CTRL_B_OFS) begin
			rd_d[7:0] = control_reg_b_q;
		end else if (paddr == ebtc_pkg::COUNT_OFS) begin
			rd_d[CNT_W-1:0] = count_value_q;
		end else if (paddr == ebtc_pkg::CMP_A_OFS) begin
			rd_d[CNT_W-1:0] = is_pwm ? cmp_buf_q[0] : cmp_act_q[0];
		end else if (paddr == ebtc_pkg::CMP_B_OFS) begin
			rd_d[CNT_W-1:0] = is_pwm ? cmp_buf_q[1] : cmp_act_q[1];
		end else if (paddr == ebtc_pkg::IMASK_OFS) begin
			rd_d[2:0] = interrupt_mask_reg_q;
		end else if (paddr == ebtc_pkg::IFLAG_OFS) begin
			rd_d[2:0] = interrupt_flag_reg_q;
		end else if (paddr == ebtc_pkg::ASYNC_OFS) begin
			rd_d[ebtc_pkg::AS_POS] = async_clock_select_q;
		end else if (paddr == ebtc_pkg::POWER_OFS) begin
			rd_d[ebtc_pkg::PRR_POS] = timer_power_reduce_bit_q;
		end
	end

	// Read data registered in the setup cycle, valid in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_ok && !penable) begin
			prdata <= rd_d;
		end
	end
endmodule

// ### ebtc_timer_assertions.sv
`timescale 1ns/100ps
// Port-level checks; control writes are shadowed to predict the outputs
module ebtc_checker #(
	parameter int CNT_W = 8
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        crystal_pin_in,
	input wire logic        overflow_ack,
	input wire logic        match_a_ack,
	input wire logic        match_b_ack,
	input wire logic        overflow_irq,
	input wire logic        match_a_irq,
	input wire logic        match_b_irq,
	input wire logic        compare_out_a,
	input wire logic        compare_out_b,
	input wire logic        compare_out_en_a,
	input wire logic        compare_out_en_b
);
	logic [7:0] ctl_a_q;
	logic [2:0] cs_q;
	logic [2:0] msk_q;
	logic       prr_q;
	logic [1:0] hold_q;
	logic       wr;
	logic       wr_a;
	logic       wr_b;
	logic       wr_m;
	logic [1:0] com_a;
	logic       stopped;

	// Completed writes, decoded per register
	assign wr    = psel && penable && pwrite && pready;
	assign wr_a  = wr && paddr == ebtc_pkg::CTRL_A_OFS;
	assign wr_b  = wr && paddr == ebtc_pkg::CTRL_B_OFS;
	assign wr_m  = wr && paddr == ebtc_pkg::IMASK_OFS;
	assign com_a = ctl_a_q[7:6];
	// Live stop state: hold_q lags a restart by one cycle
	assign stopped = cs_q == 3'h0 || prr_q;

	// Shadow of the settings that shape outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_a_q <= 8'h00;
			cs_q    <= 3'h0;
			msk_q   <= 3'h0;
			prr_q   <= 1'b0;
		end else begin
			if (wr_a)
				ctl_a_q <= pwdata[7:0];
			if (wr_b)
				cs_q <= pwdata[2:0];
			if (wr_m)
				msk_q <= pwdata[2:0];
			if (wr && paddr == ebtc_pkg::POWER_OFS)
				prr_q <= pwdata[0];
		end
	end

	// Cycles without ticks; the tick path may lag, so wait three
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_q <= 2'h0;
		else if (cs_q != 3'h0 && !prr_q)
			hold_q <= 2'h0;
		else if (hold_q != 2'h3)
			hold_q <= hold_q + 2'h1;
	end

	property p_en_a;
		@(posedge pclk) disable iff (!presetn)
		wr_a |=> compare_out_en_a == (com_a == 2'b00);
	endproperty
	a_en_a: assert property (p_en_a) else $error("enable A wrong");
	property p_en_b;
		@(posedge pclk) disable iff (!presetn)
		wr_a |=> compare_out_en_b == (ctl_a_q[5:4] == 2'b00);
	endproperty
	a_en_b: assert property (p_en_b) else $error("enable B wrong");
	property p_force_a;
		@(posedge pclk) disable iff (!presetn)
		wr_b && pwdata[7] && pwdata[2:0] == 3'h0 && hold_q == 2'h3 && stopped
		&& !ctl_a_q[0] |=>
		compare_out_a == ($past(com_a) == 2'b01 ? !$past(compare_out_a) :
		$past(com_a) == 2'b10 ? 1'b0 : $past(com_a) == 2'b11 ? 1'b1 : $past(compare_out_a));
	endproperty
	a_force_a: assert property (p_force_a) else $error("forced A wrong");
	property p_com0_a;
		@(posedge pclk) disable iff (!presetn)
		com_a == 2'b00 |=> $stable(compare_out_a);
	endproperty
	a_com0_a: assert property (p_com0_a) else $error("A moved, mode 0");
	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		hold_q == 2'h3 && stopped
		&& !(wr && (paddr == ebtc_pkg::CTRL_B_OFS || paddr == ebtc_pkg::POWER_OFS))
		|=> $stable(compare_out_a) && $stable(compare_out_b);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved, stopped");
	property p_keep_a;
		@(posedge pclk) disable iff (!presetn)
		match_a_irq && !match_a_ack && !(wr && paddr == ebtc_pkg::IFLAG_OFS && pwdata[1])
		&& !(wr_m && !pwdata[1]) |=> match_a_irq;
	endproperty
	a_keep_a: assert property (p_keep_a) else $error("A request lost");
	property p_mask_off;
		@(posedge pclk) disable iff (!presetn)
		wr_m && pwdata[2:0] == 3'h0 |=> !overflow_irq && !match_a_irq && !match_b_irq;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked request seen");
	property p_flag_rd;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == ebtc_pkg::IFLAG_OFS && msk_q[0]
		|=> prdata[0] == $past(overflow_irq);
	endproperty
	a_flag_rd: assert property (p_flag_rd) else $error("flag read wrong");
endmodule

bind ebtc_timer ebtc_checker #(.CNT_W(CNT_W)) ebtc_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .crystal_pin_in(crystal_pin_in),
	.overflow_ack(overflow_ack), .match_a_ack(match_a_ack), .match_b_ack(match_b_ack),
	.overflow_irq(overflow_irq), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
	.compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
	.compare_out_en_a(compare_out_en_a), .compare_out_en_b(compare_out_en_b)
);

// ### tb_eight_bit_timer_compare_unit.sv
`timescale 1ns/100ps
module tb_eight_bit_timer_compare_unit;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        crystal_pin_in;
	logic        overflow_ack;
	logic        match_a_ack;
	logic        match_b_ack;
	logic        overflow_irq;
	logic        match_a_irq;
	logic        match_b_irq;
	logic        compare_out_a;
	logic        compare_out_b;
	logic        compare_out_en_a;
	logic        compare_out_en_b;
	int          bad_count;
	int          num_checks;
	int          seed;
	logic [31:0] rd;
	logic [7:0]  v;
	logic        oa;

	ebtc_timer ebtc_timer_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .crystal_pin_in(crystal_pin_in),
		.overflow_ack(overflow_ack), .match_a_ack(match_a_ack), .match_b_ack(match_b_ack),
		.overflow_irq(overflow_irq), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
		.compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
		.compare_out_en_a(compare_out_en_a), .compare_out_en_b(compare_out_en_b)
	);

	// Bus clock, and a free-running crystal some seven times slower
	always #50 pclk = ~pclk;
	always #350 crystal_pin_in = ~crystal_pin_in;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// A wait that ran out ends the run
	task automatic tmo(input logic ok);
		if (!ok) begin
			bad_count++;
			$display("Error timeout");
			end_of_test();
		end
	endtask

	// One APB transfer, held until pready; read data lands in rd
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		tmo(pready === 1'b1);
		rd = prdata;
		chk("pslverr", 32'h0, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// Run the counter n cycles, then stop it keeping mode bit 2
	task automatic run(input logic [7:0] b, input int n);
		wr(ebtc_pkg::CTRL_B_OFS, {24'h0, b});
		repeat (n) @(posedge pclk);
		wr(ebtc_pkg::CTRL_B_OFS, {24'h0, b & 8'hF8});
	endtask

	function automatic logic [31:0] in_rng(input logic [7:0] x, input logic [7:0] l, h);
		return {31'h0, x >= l && x <= h};
	endfunction

	// Non-PWM output action for a compare-output setting
	function automatic logic exp_force(input logic [1:0] com, input logic cur);
		case (com)
			2'b01: return !cur;
			2'b10: return 1'b0;
			2'b11: return 1'b1;
			default: return cur;
		endcase
	endfunction

	initial begin
		{pclk, crystal_pin_in, presetn, psel, penable, pwrite} = 6'h0;
		{overflow_ack, match_a_ack, match_b_ack, paddr, pwdata} = '0;
		{bad_count, num_checks, oa} = '0;
		seed = 32'hE3DC;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values; the last address is unmapped
		for (int i = 0; i < 10; i++) begin
			rdr(8'(i * 4));
			chk("reset", 32'h0, rd);
		end
		wr(8'h24, 32'hFF);
		rdr(8'h24);
		chk("unmapped", 32'h0, rd);
		// Random values while stopped; only eight bits are kept
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			wr(ebtc_pkg::COUNT_OFS, {24'($random(seed)), v});
			rdr(ebtc_pkg::COUNT_OFS);
			chk("count", {24'h0, v}, rd);
			wr(ebtc_pkg::CMP_A_OFS, {24'h0, ~v});
			rdr(ebtc_pkg::CMP_A_OFS);
			chk("cmp_a", {24'h0, ~v}, rd);
		end
		// Normal-mode wrap raises overflow; taking it clears the flag
		wr(ebtc_pkg::IMASK_OFS, 32'h1);
		wr(ebtc_pkg::COUNT_OFS, 32'hFD);
		wr(ebtc_pkg::CTRL_B_OFS, 32'h1);
		for (int n = 0; n < 20 && overflow_irq !== 1'b1; n++) begin
			@(posedge pclk);
			#1;
		end
		tmo(overflow_irq === 1'b1);
		wr(ebtc_pkg::CTRL_B_OFS, 32'h0);
		@(posedge pclk);
		overflow_ack <= 1'b1;
		@(posedge pclk);
		overflow_ack <= 1'b0;
		#1;
		chk("ovf_ack", 32'h0, {31'h0, overflow_irq});
		// A count write hides the next match; a clean approach flags both
		wr(ebtc_pkg::CMP_A_OFS, 32'h10);
		wr(ebtc_pkg::CMP_B_OFS, 32'h10);
		wr(ebtc_pkg::IFLAG_OFS, 32'h7);
		wr(ebtc_pkg::COUNT_OFS, 32'h10);
		run(8'h01, 4);
		rdr(ebtc_pkg::IFLAG_OFS);
		chk("blocked", 32'h0, rd & 32'h6);
		// restart below the compare so the match is seen
		wr(ebtc_pkg::COUNT_OFS, 32'h0C);
		run(8'h01, 10);
		rdr(ebtc_pkg::IFLAG_OFS);
		chk("matched", 32'h6, rd & 32'h6);
		wr(ebtc_pkg::IMASK_OFS, 32'h6);
		chk("irq_on", 32'h3, {30'h0, match_b_irq, match_a_irq});
		wr(ebtc_pkg::IMASK_OFS, 32'h0);
		chk("irq_off", 32'h0, {30'h0, match_b_irq, match_a_irq});
		wr(ebtc_pkg::IMASK_OFS, 32'h6);
		wr(ebtc_pkg::IFLAG_OFS, 32'h2);
		chk("w1c", 32'h2, {30'h0, match_b_irq, match_a_irq});
		@(posedge pclk);
		match_b_ack <= 1'b1;
		@(posedge pclk);
		match_b_ack <= 1'b0;
		#1;
		chk("ack_b", 32'h0, {31'h0, match_b_irq});
		// Software write beats a tick in the same cycle
		wr(ebtc_pkg::CTRL_B_OFS, 32'h1);
		wr(ebtc_pkg::COUNT_OFS, 32'h80);
		rdr(ebtc_pkg::COUNT_OFS);
		chk("cnt_wr", 32'h1, in_rng(rd[7:0], 8'h80, 8'h84));
		wr(ebtc_pkg::CTRL_B_OFS, 32'h0);
		// Clear on match never passes compare A
		wr(ebtc_pkg::CTRL_A_OFS, 32'h2);
		wr(ebtc_pkg::CMP_A_OFS, 32'h5);
		wr(ebtc_pkg::COUNT_OFS, 32'h0);
		wr(ebtc_pkg::CTRL_B_OFS, 32'h1);
		for (int i = 0; i < 6; i++) begin
			rdr(ebtc_pkg::COUNT_OFS);
			chk("ctc", 32'h1, in_rng(rd[7:0], 8'h00, 8'h05));
		end
		// Fast PWM on A: a new top waits in the buffer until top
		wr(ebtc_pkg::CTRL_B_OFS, 32'h0);
		wr(ebtc_pkg::CMP_A_OFS, 32'h30);
		wr(ebtc_pkg::CTRL_A_OFS, 32'h3);
		wr(ebtc_pkg::COUNT_OFS, 32'h28);
		wr(ebtc_pkg::CTRL_B_OFS, 32'h8);
		wr(ebtc_pkg::CMP_A_OFS, 32'h8);
		rdr(ebtc_pkg::CMP_A_OFS);
		chk("buf_rd", 32'h8, rd);
		run(8'h09, 40);
		rdr(ebtc_pkg::COUNT_OFS);
		chk("fast_top", 32'h1, in_rng(rd[7:0], 8'h00, 8'h08));
		// Phase correct turns at 0xFF and counts down
		wr(ebtc_pkg::CTRL_B_OFS, 32'h0);
		wr(ebtc_pkg::CTRL_A_OFS, 32'h1);
		wr(ebtc_pkg::COUNT_OFS, 32'hF0);
		wr(ebtc_pkg::CTRL_B_OFS, 32'h1);
		repeat (40) @(posedge pclk);
		rdr(ebtc_pkg::COUNT_OFS);
		v = rd[7:0];
		rdr(ebtc_pkg::COUNT_OFS);
		wr(ebtc_pkg::CTRL_B_OFS, 32'h0);
		chk("pc_down", 32'h1, {31'h0, rd[7:0] < v});
		// Power reduction freezes the count
		wr(ebtc_pkg::POWER_OFS, 32'h1);
		wr(ebtc_pkg::CTRL_A_OFS, 32'h0);
		wr(ebtc_pkg::COUNT_OFS, 32'h40);
		run(8'h01, 20);
		rdr(ebtc_pkg::COUNT_OFS);
		chk("pwr_off", 32'h40, rd);
		wr(ebtc_pkg::POWER_OFS, 32'h0);
		run(8'h01, 5);
		rdr(ebtc_pkg::COUNT_OFS);
		chk("pwr_on", 32'h1, in_rng(rd[7:0], 8'h41, 8'h50));
		// Clock select 2 divides the bus clock by eight
		wr(ebtc_pkg::COUNT_OFS, 32'h0);
		run(8'h02, 40);
		rdr(ebtc_pkg::COUNT_OFS);
		chk("div8", 32'h1, in_rng(rd[7:0], 8'h04, 8'h06));
		// Crystal source counts far slower than the bus clock
		wr(ebtc_pkg::ASYNC_OFS, 32'h8);
		wr(ebtc_pkg::COUNT_OFS, 32'h0);
		run(8'h01, 40);
		rdr(ebtc_pkg::COUNT_OFS);
		chk("async", 32'h1, in_rng(rd[7:0], 8'h02, 8'h0A));
		wr(ebtc_pkg::ASYNC_OFS, 32'h0);
		// Every output setting, forced, then kept over a mode change
		wr(ebtc_pkg::IFLAG_OFS, 32'h7);
		for (int i = 0; i < 8; i++) begin
			v = 8'(i % 4);
			wr(ebtc_pkg::CTRL_A_OFS, {24'h0, v[1:0], v[1:0], 4'h0});
			chk("en_a", {31'h0, v[1:0] == 2'b00}, {31'h0, compare_out_en_a});
			// output state set by force in normal mode
			wr(ebtc_pkg::CTRL_B_OFS, 32'hC0);
			oa = exp_force(v[1:0], oa);
			chk("force", {30'h0, oa, oa}, {30'h0, compare_out_b, compare_out_a});
			wr(ebtc_pkg::CTRL_A_OFS, {24'h0, v[1:0], v[1:0], 4'h3});
			chk("keep", {30'h0, oa, oa}, {30'h0, compare_out_b, compare_out_a});
		end
		rdr(ebtc_pkg::IFLAG_OFS);
		chk("force_flag", 32'h0, rd & 32'h6);
		end_of_test();
	end
endmodule
